// *** idh_checker.sv ***
// checker: dispatch link assertions
`default_nettype none
module idh_checker (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic interrupt_request_n,
  input wire logic hold_request_n,
  input wire logic address_strobe,
  input wire logic dma_enable_flag,
  input wire logic dma_request_n,
  input wire logic dma_ack_n,
  input wire logic precharge_clock,
  input wire logic phase_two_clock,
  input wire logic irq_ctrl_bit_a,
  input wire logic irq_ctrl_bit_b,
  input wire logic irq_ctrl_bit_c,
  input wire logic instr_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd;
  logic ack;
  logic frz;
  logic [5:0] hcnt;
  assign rd = irq_ctrl_bit_a & ~irq_ctrl_bit_b & irq_ctrl_bit_c;
  assign ack = irq_ctrl_bit_a & irq_ctrl_bit_b & ~irq_ctrl_bit_c;
  assign frz = ~dma_ack_n & ~precharge_clock & phase_two_clock;
  // steady hold count; 24 covers the request's sync lag
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || hold_request_n) hcnt <= 6'h00;
    else if (hcnt != 6'h3f) hcnt <= hcnt + 6'h01;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence vec_read_s; $rose(rd); endsequence
  sequence vec_done_s; ##[1:30] ack ##[1:30] instr_end; endsequence
  end_gap_a: assert property (instr_end |=> !instr_end [*8])
    else $error("instruction ends too close");
  vec_seq_a: assert property (vec_read_s |-> vec_done_s)
    else $error("vector read not followed by clear");
  vec_cause_a: assert property (vec_read_s |-> !interrupt_request_n)
    else $error("vector read without request");
  hold_prio_a: assert property (hcnt >= 6'h18 |-> !$rose(rd))
    else $error("interrupt served during hold");
  dma_ack_a: assert property ((dma_enable_flag && !dma_request_n) [*2]
    |-> ##[0:12] (!dma_ack_n || dma_request_n || !dma_enable_flag))
    else $error("dma request not acknowledged");
  dma_freeze_a: assert property ($fell(dma_ack_n)
    |-> ##[0:14] (frz || dma_ack_n)) else $error("clocks not frozen");
  freeze_stall_a: assert property (frz [*5] |-> !instr_end &&
    $stable({irq_ctrl_bit_a, irq_ctrl_bit_b, irq_ctrl_bit_c}))
    else $error("sequencing while frozen");
  ack_release_a: assert property ($rose(dma_request_n)
    |-> ##[0:12] dma_ack_n) else $error("dma acknowledge kept");
  hold_sync_a: assert property ($changed(hold_request_n)
    |-> $fell(address_strobe)) else $error("hold moved off strobe fall");
endmodule : idh_checker
`default_nettype wire

// *** idh_control_unit.sv ***
// control unit end: prefetch pipeline, dispatch and boundary arbitration
// Summary of operation
// - microroutines kept in a microcode store
// - words enter two-stage prefetch pipeline
// - stage two selected after previous routine
// - first address is constant plus opcode
// - next instruction unless request pending
// - hold wins over interrupt at boundary
// - one instruction runs after hold release
// - dma stops at machine cycle end
// - partner acknowledges dma request when enabled
// - partner freezes clocks on dma acknowledge
// - frozen during dma, resume same microinstruction
// - sample interrupt request at routine end
// - three microcode bits steer interrupt unit
// - vector read clears pending interrupt
// - sample hold request at routine end
// - resume exactly where hold was accepted
// - hardware hold ends high, breakpoint by pulse
// - partner syncs hold to strobe falling
`default_nettype none
module idh_control_unit
  import idh_pkg::*;
#(
  parameter int ROUTINE_LEN = UROUTINE_LEN
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  idh_link_if.control_unit link,
  output logic [UADDR_W-1:0] uaddr_o,
  output logic [DATA_W-1:0] vector_o,
  output logic vector_valid_o,
  output logic in_hold_o,
  output logic running_o
);
  typedef enum logic [4:0] {
    ST_FILL = 5'b0_0001,
    ST_EXEC = 5'b0_0010,
    ST_IRQ = 5'b0_0100,
    ST_HOLD = 5'b0_1000,
    ST_REL = 5'b1_0000
  } idh_state_t;

  typedef struct packed {
    idh_state_t st;
    logic [DATA_W-1:0] stage_one;
    logic [DATA_W-1:0] stage_two;
    logic one_full;
    logic two_full;
    logic [UADDR_W-1:0] uaddr;
    logic [3:0] step;
    logic hold_by_breakpoint;
    logic saw_release;
    logic skip_irq;
    logic [2:0] irq_cmd;
    logic [DATA_W-1:0] vector;
    logic vector_valid;
    logic end_pulse;
    logic [2:0] clk_pc_s;
    logic [2:0] clk_p2_s;
    logic [1:0] irq_s;
    logic [1:0] hold_s;
    logic [1:0] ack_s;
  } idh_ctrl_t;

  idh_ctrl_t r;
  idh_ctrl_t next_r;
  logic frozen;
  logic mcycle;
  logic irq_req;
  logic hold_req;

  // partner levels are re-timed here: two cycles of lag (three for the clocks) buy a clean
  // decode should the partner ever move to another clock
  // dma freeze as seen through the two synchronised clocks
  assign frozen = !r.ack_s[1] && !r.clk_pc_s[2] && r.clk_p2_s[2];
  // one machine cycle completes on each rising edge of phase two
  assign mcycle = r.clk_p2_s[1] && !r.clk_p2_s[2] && !frozen;
  assign irq_req = !r.irq_s[1];
  assign hold_req = !r.hold_s[1];

  always_comb begin
    next_r = r;
    next_r.clk_pc_s = {r.clk_pc_s[1:0], link.precharge_clock};
    next_r.clk_p2_s = {r.clk_p2_s[1:0], link.phase_two_clock};
    next_r.irq_s = {r.irq_s[0], link.interrupt_request_n};
    next_r.hold_s = {r.hold_s[0], link.hold_request_n};
    next_r.ack_s = {r.ack_s[0], link.dma_ack_n};
    next_r.end_pulse = 1'b0;
    next_r.vector_valid = 1'b0;
    // prefetch: stage one hands on to stage two when it is free
    if (link.ad_valid && !r.one_full) begin
      next_r.stage_one = link.ad_bus;
      next_r.one_full = 1'b1;
    end
    if (r.one_full && !r.two_full) begin
      next_r.stage_two = r.stage_one;
      next_r.two_full = 1'b1;
      next_r.one_full = link.ad_valid && !r.one_full;
    end
    // all sequencing advances only on completed machine cycles
    if (mcycle) begin
      case (r.st)
        ST_FILL, ST_REL: begin
          // requests are looked at only here, at the boundary
          // a breakpoint hold is not re-entered on its own release cycle
          if (hold_req && !(r.st == ST_REL && r.hold_by_breakpoint)) begin
            next_r.st = ST_HOLD;
            next_r.hold_by_breakpoint = 1'b0;
            next_r.saw_release = 1'b0;
            next_r.step = '0;
          end else if (irq_req && !r.skip_irq) begin
            next_r.st = ST_IRQ;
            next_r.step = '0;
            next_r.irq_cmd = IRQ_CMD_READ_VEC;
          end else if (r.two_full) begin
            // dispatch from stage two; stage one moves up behind it
            next_r.uaddr = {DISPATCH_BASE,
                            r.stage_two[DATA_W-1 -: OPC_W]};
            next_r.two_full = 1'b0;
            next_r.skip_irq = 1'b0;
            next_r.step = '0;
            next_r.st = ST_EXEC;
            if (r.stage_two[DATA_W-1 -: OPC_W] == BREAKPOINT_OPC) begin
              next_r.st = ST_HOLD; // software breakpoint enters hold
              next_r.hold_by_breakpoint = 1'b1;
              next_r.saw_release = 1'b0;
            end
          end else begin
            next_r.st = ST_FILL;
          end
        end
        ST_EXEC: begin
          // microsequencer steps the store address inside the routine
          // fixed-length routines stand in for the store: every opcode but
          // the breakpoint takes ROUTINE_LEN machine cycles
          next_r.uaddr = r.uaddr + UADDR_W'(1);
          next_r.step = r.step + 4'(1);
          if (32'(r.step) == ROUTINE_LEN - 1) begin
            next_r.st = ST_FILL;
            next_r.end_pulse = 1'b1;
          end
        end
        ST_IRQ: begin
          // step one reads the vector and has the partner clear it
          next_r.step = r.step + 4'(1);
          if (r.step == 4'(1)) begin
            next_r.vector = link.vector_code;
            next_r.vector_valid = 1'b1;
            next_r.irq_cmd = IRQ_CMD_ACK;
          end
          if (32'(r.step) == IRQ_ROUTINE_LEN - 1) begin
            next_r.irq_cmd = IRQ_CMD_IDLE;
            next_r.st = ST_FILL;
            next_r.end_pulse = 1'b1;
          end
        end
        ST_HOLD: begin
          // pc/stage contents untouched, so execution resumes in place
          // a breakpoint pulse shorter than a machine cycle can be missed,
          // since the request is only looked at on machine cycles
          if (r.hold_by_breakpoint) begin
            if (hold_req) begin
              next_r.saw_release = 1'b1;
            end else if (r.saw_release) begin
              next_r.st = ST_REL;
              next_r.skip_irq = 1'b1;
            end
          end else if (!hold_req) begin
            next_r.st = ST_REL;
            next_r.skip_irq = 1'b1;
          end
        end
        default: begin
          next_r.st = ST_FILL;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      r <= '0;
      r.st <= ST_FILL;
      // synchronisers start at idle levels so no false edge follows
      r.clk_pc_s <= 3'h7;
      r.irq_s <= 2'h3;
      r.hold_s <= 2'h3;
      r.ack_s <= 2'h3;
    end else begin
      r <= next_r;
    end
  end

  assign link.ad_ready = !r.one_full;
  assign link.irq_ctrl_bit_a = r.irq_cmd[0];
  assign link.irq_ctrl_bit_b = r.irq_cmd[1];
  assign link.irq_ctrl_bit_c = r.irq_cmd[2];
  assign link.instr_end = r.end_pulse;
  assign uaddr_o = r.uaddr;
  assign vector_o = r.vector;
  assign vector_valid_o = r.vector_valid;
  assign in_hold_o = (r.st == ST_HOLD);
  assign running_o = (r.st == ST_EXEC);
endmodule : idh_control_unit
`default_nettype wire

// *** idh_link_if.sv ***
// interface: link between the dispatch unit and its companion units
`default_nettype none
interface idh_link_if;
  import idh_pkg::*;
  logic [DATA_W-1:0] ad_bus;
  logic ad_valid;
  logic ad_ready;
  logic address_strobe;
  logic interrupt_request_n;
  logic hold_request_n;
  logic dma_enable_flag;
  logic dma_request_n;
  logic dma_ack_n;
  logic precharge_clock;
  logic phase_two_clock;
  logic irq_ctrl_bit_a;
  logic irq_ctrl_bit_b;
  logic irq_ctrl_bit_c;
  logic [DATA_W-1:0] vector_code;
  logic instr_end;
  modport control_unit(
    input ad_bus, ad_valid, interrupt_request_n, hold_request_n,
    input dma_ack_n, precharge_clock, phase_two_clock, vector_code,
    output ad_ready, irq_ctrl_bit_a, irq_ctrl_bit_b, irq_ctrl_bit_c,
    output instr_end
  );
  modport partner(
    output ad_bus, ad_valid, address_strobe, interrupt_request_n,
    output hold_request_n, dma_enable_flag, dma_request_n, dma_ack_n,
    output precharge_clock, phase_two_clock, vector_code,
    input ad_ready, irq_ctrl_bit_a, irq_ctrl_bit_b, irq_ctrl_bit_c,
    input instr_end
  );
endinterface : idh_link_if
`default_nettype wire

// *** idh_partner.sv ***
// partner end: clocks, dma acknowledge, interrupt pending and hold
`default_nettype none
module idh_partner
  import idh_pkg::*;
#(
  parameter int CLK_DIV = 5
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  idh_link_if.partner link,
  input wire logic [DATA_W-1:0] word_i,
  input wire logic word_valid_i,
  output logic word_ready_o,
  input wire logic dma_enable_i,
  input wire logic dma_request_n_i,
  input wire logic irq_raise_i,
  input wire logic [DATA_W-1:0] irq_vector_i,
  input wire logic hold_request_n_i,
  output logic dma_ack_n_o,
  output logic irq_pending_o
);
  typedef struct packed {
    logic [3:0] div;
    logic pc;
    logic p2;
    logic ack_n;
    logic pending;
    logic [DATA_W-1:0] vec;
    logic hold_n;
    logic strobe;
    logic [2:0] cmd_d;
  } idh_pt_t;

  idh_pt_t r;
  idh_pt_t next_r;
  logic [2:0] cmd;

  assign cmd = {link.irq_ctrl_bit_c, link.irq_ctrl_bit_b,
                link.irq_ctrl_bit_a};

  always_comb begin
    next_r = r;
    next_r.cmd_d = cmd;
    // acknowledge only while enabled and requested
    next_r.ack_n = !(dma_enable_i && !dma_request_n_i);
    if (!r.ack_n) begin
      next_r.pc = 1'b0;
      next_r.p2 = 1'b1;
    end else if (32'(r.div) == CLK_DIV - 1) begin
      next_r.div = '0;
      next_r.p2 = !r.p2;
      next_r.pc = r.p2;
    end else begin
      next_r.div = r.div + 4'(1);
    end
    next_r.strobe = next_r.div == 4'(0);
    // hold changes only at the strobe edge
    if (r.strobe && !next_r.strobe) begin
      next_r.hold_n = hold_request_n_i;
    end
    // raise wins over a clear in the same cycle
    if (irq_raise_i) begin
      next_r.pending = 1'b1;
      next_r.vec = irq_vector_i;
    end else if (cmd == IRQ_CMD_ACK && r.cmd_d != IRQ_CMD_ACK) begin
      next_r.pending = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      r <= '0;
      r.ack_n <= 1'b1;
      r.pc <= 1'b1;
      r.hold_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.ad_bus = word_i;
  assign link.ad_valid = word_valid_i;
  assign word_ready_o = link.ad_ready;
  assign link.address_strobe = r.strobe;
  assign link.interrupt_request_n = !r.pending;
  assign link.hold_request_n = r.hold_n;
  assign link.dma_enable_flag = dma_enable_i;
  assign link.dma_request_n = dma_request_n_i;
  assign link.dma_ack_n = r.ack_n;
  assign link.precharge_clock = r.pc;
  assign link.phase_two_clock = r.p2;
  assign link.vector_code = r.vec;
  assign dma_ack_n_o = r.ack_n;
  assign irq_pending_o = r.pending;
endmodule : idh_partner
`default_nettype wire

// *** idh_pkg.sv ***
// package: constants shared by both ends of the dispatch link
`default_nettype none
package idh_pkg;
  localparam int OPC_W = 8;
  localparam int UADDR_W = 12;
  localparam int DATA_W = 16;
  localparam logic [3:0] DISPATCH_BASE = 4'h8;
  localparam int ISA_ROUTINE_LOCS = 1255;
  localparam int UROUTINE_LEN = 4;
  localparam int IRQ_ROUTINE_LEN = 3;
  localparam int HOLD_ROUTINE_LEN = 2;
  localparam logic [OPC_W-1:0] BREAKPOINT_OPC = 8'hff;
  localparam logic [2:0] IRQ_CMD_IDLE = 3'h0;
  localparam logic [2:0] IRQ_CMD_READ_VEC = 3'h5;
  localparam logic [2:0] IRQ_CMD_ACK = 3'h3;
endpackage : idh_pkg
`default_nettype wire

// *** tb_top.sv ***
// testbench: both ends of the dispatch link joined
`default_nettype none
module tb_top
  import idh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [DATA_W-1:0] word_i = 16'h0100;
  logic word_valid_i = 1'b0;
  logic dma_enable_i = 1'b0;
  logic dma_request_n_i = 1'b1;
  logic irq_raise_i = 1'b0;
  logic [DATA_W-1:0] irq_vector_i = 16'h0000;
  logic hold_request_n_i = 1'b1;
  logic word_ready_o, dma_ack_n_o, irq_pending_o;
  logic vector_valid_o, in_hold_o, running_o;
  logic [UADDR_W-1:0] uaddr_o, u0;
  logic [DATA_W-1:0] vector_o;
  int bad_count = 0, total_checks = 0, ends = 0, vecs = 0, v0, e0;
  time t0;
  logic [7:0] prog[$];
  idh_link_if link();
  always #5 mclk_i = ~mclk_i;
  idh_control_unit idh_control_unit_inst (.mclk_i, .reset_n_i,
    .link(link.control_unit), .uaddr_o, .vector_o, .vector_valid_o,
    .in_hold_o, .running_o);
  idh_partner idh_partner_inst (.mclk_i, .reset_n_i, .link(link.partner),
    .word_i, .word_valid_i, .word_ready_o, .dma_enable_i, .dma_request_n_i,
    .irq_raise_i, .irq_vector_i, .hold_request_n_i, .dma_ack_n_o,
    .irq_pending_o);
  idh_checker idh_checker_inst (.mclk_i, .reset_n_i,
    .interrupt_request_n(link.interrupt_request_n),
    .hold_request_n(link.hold_request_n),
    .address_strobe(link.address_strobe),
    .dma_enable_flag(link.dma_enable_flag),
    .dma_request_n(link.dma_request_n), .dma_ack_n(link.dma_ack_n),
    .precharge_clock(link.precharge_clock),
    .phase_two_clock(link.phase_two_clock),
    .irq_ctrl_bit_a(link.irq_ctrl_bit_a),
    .irq_ctrl_bit_b(link.irq_ctrl_bit_b),
    .irq_ctrl_bit_c(link.irq_ctrl_bit_c), .instr_end(link.instr_end));
  // no-op words keep the prefetch path full between test opcodes
  always @(posedge mclk_i) begin
    if (word_valid_i && word_ready_o) begin
      word_i <= {(prog.size() > 0) ? prog.pop_front() : 8'h01, 8'h00};
    end
    ends <= ends + int'(link.instr_end);
    vecs <= vecs + int'(vector_valid_o);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic cond(input int k, input logic [7:0] opc);
    case (k)
      0: return uaddr_o === {DISPATCH_BASE, opc};
      1: return vector_valid_o === 1'b1;
      2: return in_hold_o === 1'b1;
      3: return in_hold_o === 1'b0;
      4: return dma_ack_n_o === 1'b0;
      default: return irq_pending_o === 1'b0;
    endcase
  endfunction : cond
  task automatic wait_until(input int k, input int lim, input logic [7:0] opc);
    int n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (!cond(k, opc) && n < lim);
    chk(cond(k, opc), 1'b1);
    t0 = $time;
    @(posedge mclk_i);
  endtask : wait_until
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100_000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    word_valid_i <= 1'b1;
    prog.push_back(8'h12);
    prog.push_back(8'h34);
    wait_until(0, 400, 8'h12);
    chk(running_o, 1'b1);
    wait_until(0, 70, 8'h34);
    irq_vector_i <= 16'ha5c3;
    irq_raise_i <= 1'b1;
    @(posedge mclk_i);
    irq_raise_i <= 1'b0;
    wait_until(1, 200, 8'h00);
    chk(vector_o, 16'ha5c3);
    wait_until(5, 40, 8'h00);
    v0 = vecs;
    hold_request_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    irq_vector_i <= 16'h0042;
    irq_raise_i <= 1'b1;
    @(posedge mclk_i);
    irq_raise_i <= 1'b0;
    wait_until(2, 200, 8'h00);
    chk(vecs, v0);
    repeat (60) @(posedge mclk_i);
    chk({in_hold_o, irq_pending_o}, 2'b11);
    chk({running_o, word_ready_o}, 2'b00);
    hold_request_n_i <= 1'b1;
    wait_until(3, 100, 8'h00);
    e0 = int'(t0);
    // one whole instruction must run before the vector is fetched
    wait_until(1, 300, 8'h00);
    chk(t0 - e0 >= UROUTINE_LEN * 100, 1'b1);
    dma_request_n_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    chk(dma_ack_n_o, 1'b1);
    dma_enable_i <= 1'b1;
    wait_until(4, 20, 8'h00);
    repeat (20) @(posedge mclk_i);
    u0 = uaddr_o;
    e0 = ends;
    repeat (50) @(posedge mclk_i);
    chk({uaddr_o, ends == e0}, {u0, 1'b1});
    dma_request_n_i <= 1'b1;
    repeat (70) @(posedge mclk_i);
    chk(ends > e0, 1'b1);
    prog.push_back(BREAKPOINT_OPC);
    wait_until(2, 400, 8'h00);
    repeat (40) @(posedge mclk_i);
    chk(in_hold_o, 1'b1);
    hold_request_n_i <= 1'b0;
    repeat (30) @(posedge mclk_i);
    hold_request_n_i <= 1'b1;
    wait_until(3, 100, 8'h00);
    prog.push_back(8'h77);
    wait_until(0, 400, 8'h77);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
